// ---- verilog/pwm_decode_pkg.sv ----
package pwm_decode_pkg;

  // Scheme selection codes
  localparam logic [1:0] SCHEME_SIX    = 2'h0;
  localparam logic [1:0] SCHEME_THREE  = 2'h1;
  localparam logic [1:0] SCHEME_SINGLE = 2'h2;
  localparam logic [1:0] SCHEME_INDEP  = 2'h3;

  // Rotor state codes for direction 0
  localparam logic [2:0] ROTOR_STOP  = 3'h0;
  localparam logic [2:0] ROTOR_ALIGN = 3'h7;
  localparam logic [2:0] ROTOR_B_TO_C = 3'h6;
  localparam logic [2:0] ROTOR_A_TO_C = 3'h4;
  localparam logic [2:0] ROTOR_A_TO_B = 3'h5;
  localparam logic [2:0] ROTOR_C_TO_B = 3'h1;
  localparam logic [2:0] ROTOR_C_TO_A = 3'h3;
  localparam logic [2:0] ROTOR_B_TO_A = 3'h2;

  // Gate command value after reset: all gates off
  localparam logic [2:0] GATES_RESET = 3'h0;

  // Per-phase inputs and gate commands, bit 0 = phase A
  typedef struct packed {
    logic [2:0] phase_high_input;
    logic [2:0] phase_low_input;
  } phase_inputs_t;

  typedef struct packed {
    logic [2:0] high_gate_cmd;
    logic [2:0] low_gate_cmd;
  } gate_cmds_t;

endpackage : pwm_decode_pkg

// ---- verilog/three_phase_pwm_input_decoder.sv ----
`timescale 1ns/100ps
`default_nettype none

module three_phase_pwm_input_decoder
  import pwm_decode_pkg::*;
(
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  // Scheme control
  input  wire logic [1:0]                   scheme_select,
  input  wire logic                         freewheel_select_bit,
  // Controller inputs
  input  wire pwm_decode_pkg::phase_inputs_t phase_in,
  // Gate commands
  output var  pwm_decode_pkg::gate_cmds_t   gate_out
);
  import pwm_decode_pkg::*;

  gate_cmds_t gate_nxt;
  logic       pulse;
  logic       dir;
  logic       brake_n;
  logic [2:0] rotor_raw;
  logic [2:0] rotor;

  // Single-input pin roles
  assign pulse     = phase_in.phase_high_input[0];
  assign rotor_raw = {phase_in.phase_low_input[0], phase_in.phase_high_input[1],
                      phase_in.phase_low_input[1]};
  assign dir       = phase_in.phase_high_input[2];
  assign brake_n   = phase_in.phase_low_input[2];
  // Direction 1 reads the complement code; stop and align keep their codes
  assign rotor     = (dir && rotor_raw != ROTOR_STOP && rotor_raw != ROTOR_ALIGN) ?
                     ~rotor_raw : rotor_raw;

  // Source/sink drive for the commutation table
  function automatic gate_cmds_t commutate(input logic [1:0] src, input logic [1:0] snk,
                                           input logic p, input logic fw);
    gate_cmds_t g;
    g = '0;
    g.high_gate_cmd[src] = p;
    g.low_gate_cmd[src]  = fw ? 1'b0 : ~p;
    g.low_gate_cmd[snk]  = 1'b1;
    return g;
  endfunction

  // Single-input commutation decode
  function automatic gate_cmds_t single_decode(input logic [2:0] r, input logic p,
                                               input logic fw);
    gate_cmds_t g;
    g = '0;
    unique case (r)
      ROTOR_STOP:   g = '0;
      ROTOR_ALIGN: begin
        g = commutate(2'h0, 2'h1, p, fw);
        g.low_gate_cmd[2] = 1'b1;
      end
      ROTOR_B_TO_C: g = commutate(2'h1, 2'h2, p, fw);
      ROTOR_A_TO_C: g = commutate(2'h0, 2'h2, p, fw);
      ROTOR_A_TO_B: g = commutate(2'h0, 2'h1, p, fw);
      ROTOR_C_TO_B: g = commutate(2'h2, 2'h1, p, fw);
      ROTOR_C_TO_A: g = commutate(2'h2, 2'h0, p, fw);
      ROTOR_B_TO_A: g = commutate(2'h1, 2'h0, p, fw);
    endcase
    return g;
  endfunction

  // Scheme mapping; selection already resolved upstream
  always_comb begin
    gate_nxt = '0;
    unique case (scheme_select)
      SCHEME_SIX: begin
        gate_nxt.high_gate_cmd = phase_in.phase_high_input & ~phase_in.phase_low_input;
        gate_nxt.low_gate_cmd  = phase_in.phase_low_input & ~phase_in.phase_high_input;
      end
      SCHEME_THREE: begin
        gate_nxt.high_gate_cmd = phase_in.phase_low_input & phase_in.phase_high_input;
        gate_nxt.low_gate_cmd  = phase_in.phase_low_input & ~phase_in.phase_high_input;
      end
      SCHEME_SINGLE: begin
        if (!brake_n) begin
          gate_nxt.high_gate_cmd = 3'h0;
          gate_nxt.low_gate_cmd  = 3'h7;
        end else begin
          gate_nxt = single_decode(rotor, pulse, freewheel_select_bit);
        end
      end
      SCHEME_INDEP: begin
        gate_nxt.high_gate_cmd = phase_in.phase_high_input;
        gate_nxt.low_gate_cmd  = phase_in.phase_low_input;
      end
    endcase
  end

  // Registered gate commands, all off in reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_out.high_gate_cmd <= GATES_RESET;
      gate_out.low_gate_cmd  <= GATES_RESET;
    end else begin
      gate_out <= gate_nxt;
    end
  end

  // Checks
  AST_SIX_NO_OVERLAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SIX |=> (gate_out.high_gate_cmd & gate_out.low_gate_cmd) == 3'h0)
    else $error("six-input drove both gates of a phase");
  AST_SIX_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SIX && phase_in.phase_high_input[0] && !phase_in.phase_low_input[0]
    |=> gate_out.high_gate_cmd[0] && !gate_out.low_gate_cmd[0])
    else $error("six-input high not applied");
  AST_THREE_ENABLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_THREE |=>
    (gate_out.high_gate_cmd | gate_out.low_gate_cmd) == $past(phase_in.phase_low_input))
    else $error("three-input enable mismatch");
  AST_THREE_LEVEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_THREE && phase_in.phase_low_input[1]
    |=> gate_out.high_gate_cmd[1] == $past(phase_in.phase_high_input[1]))
    else $error("three-input level mismatch");
  AST_BRAKE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && !brake_n
    |=> gate_out.high_gate_cmd == 3'h0 && gate_out.low_gate_cmd == 3'h7)
    else $error("brake not applied");
  AST_STOP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && brake_n && rotor == ROTOR_STOP |=> gate_out == '0)
    else $error("stop state drove a gate");
  AST_A_TO_C: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && brake_n && !dir && rotor_raw == 3'h4
    |=> gate_out.high_gate_cmd == {2'b00, $past(pulse)} && gate_out.low_gate_cmd[2])
    else $error("A to C path wrong");
  AST_REVERSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && brake_n && dir && rotor_raw == 3'h1
    |=> gate_out.low_gate_cmd[2] && gate_out.high_gate_cmd[2] == 1'b0)
    else $error("reverse B to C path wrong");
  AST_FREEWHEEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && brake_n && freewheel_select_bit && rotor == ROTOR_ALIGN
    |=> !gate_out.low_gate_cmd[0])
    else $error("freewheel low gate not off");
  AST_SYNC_ALIGN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && brake_n && !freewheel_select_bit && rotor == ROTOR_ALIGN
    |=> gate_out.low_gate_cmd[0] == !$past(pulse) && gate_out.low_gate_cmd[2:1] == 2'b11)
    else $error("sync align wrong");
  AST_INDEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_INDEP |=> gate_out == $past(phase_in))
    else $error("independent pass-through wrong");

  // Six-input and three-input per-phase levels
  AST_SIX_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SIX && phase_in.phase_low_input[1] && !phase_in.phase_high_input[1]
    |=> gate_out.low_gate_cmd[1] && !gate_out.high_gate_cmd[1])
    else $error("six-input low not applied");
  AST_SIX_BOTH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SIX && phase_in.phase_low_input[2] && phase_in.phase_high_input[2]
    |=> !gate_out.low_gate_cmd[2] && !gate_out.high_gate_cmd[2])
    else $error("six-input both asserted did not float");
  AST_THREE_FLOAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_THREE && !phase_in.phase_low_input[2]
    |=> !gate_out.low_gate_cmd[2] && !gate_out.high_gate_cmd[2])
    else $error("three-input disabled phase not floating");

  // Rotor table for direction 0; stop in both directions, align in direction 1
  AST_DIR_STOP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && brake_n && rotor_raw == ROTOR_STOP
    |=> gate_out == '0)
    else $error("stop state with either direction drove a gate");
  AST_DIR_ALIGN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && brake_n && dir && rotor_raw == ROTOR_ALIGN
    |=> gate_out.high_gate_cmd == {2'h0, $past(pulse)}
        && gate_out.low_gate_cmd[2:1] == 2'h3)
    else $error("align with direction 1 wrong");
  AST_B_TO_C: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && brake_n && !dir && rotor_raw == ROTOR_B_TO_C
    |=> gate_out.high_gate_cmd == {1'h0, $past(pulse), 1'h0}
        && gate_out.low_gate_cmd[2] && !gate_out.low_gate_cmd[0])
    else $error("B to C path wrong");
  AST_A_TO_B: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && brake_n && !dir && rotor_raw == ROTOR_A_TO_B
    |=> gate_out.high_gate_cmd == {2'h0, $past(pulse)}
        && gate_out.low_gate_cmd[1] && !gate_out.low_gate_cmd[2])
    else $error("A to B path wrong");
  AST_C_TO_B: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && brake_n && !dir && rotor_raw == ROTOR_C_TO_B
    |=> gate_out.high_gate_cmd == {$past(pulse), 2'h0}
        && gate_out.low_gate_cmd[1] && !gate_out.low_gate_cmd[0])
    else $error("C to B path wrong");
  AST_C_TO_A: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && brake_n && !dir && rotor_raw == ROTOR_C_TO_A
    |=> gate_out.high_gate_cmd == {$past(pulse), 2'h0}
        && gate_out.low_gate_cmd[0] && !gate_out.low_gate_cmd[1])
    else $error("C to A path wrong");
  AST_B_TO_A: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && brake_n && !dir && rotor_raw == ROTOR_B_TO_A
    |=> gate_out.high_gate_cmd == {1'h0, $past(pulse), 1'h0}
        && gate_out.low_gate_cmd[0] && !gate_out.low_gate_cmd[2])
    else $error("B to A path wrong");
  AST_SYNC_SOURCE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && brake_n && !freewheel_select_bit
    && rotor == ROTOR_B_TO_C
    |=> gate_out.low_gate_cmd[1] == !$past(pulse))
    else $error("sourcing low gate not inverted pulse");

  // Main scenarios
  COV_BRAKE: cover property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && !brake_n);
  COV_REVERSE: cover property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && dir && brake_n && rotor == ROTOR_B_TO_A);
  COV_THREE_FLOAT: cover property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_THREE && phase_in.phase_low_input == 3'h0);
  COV_INDEP_BOTH: cover property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_INDEP && (phase_in.phase_high_input & phase_in.phase_low_input) != 3'h0);
  COV_REVERSE_ALIGN: cover property (@(posedge sys_clk) disable iff (!rst_n)
    scheme_select == SCHEME_SINGLE && dir && brake_n && rotor_raw == ROTOR_ALIGN);

endmodule // three_phase_pwm_input_decoder

`default_nettype wire

// ---- sim/ctrl_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module ctrl_model
  import pwm_decode_pkg::*;
(
  // Controller pins
  output var pwm_decode_pkg::phase_inputs_t phase_in
);
  // Pins idle low
  initial phase_in = '0;

  // Drive all six pins at once
  task automatic put(input logic [2:0] hi, input logic [2:0] lo);
    phase_in = '{hi, lo};
  endtask

  // Single-input roles onto pins
  task automatic put_single(input logic p, input logic [2:0] rot, input logic dir,
                            input logic brake_n);
    put({dir, rot[1], p}, {brake_n, rot[0], rot[2]});
  endtask
endmodule // ctrl_model

`default_nettype wire

// ---- sim/tb_three_phase_pwm_input_decoder.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_three_phase_pwm_input_decoder;
  import pwm_decode_pkg::*;
  // Source and sink phase masks per rotor code
  localparam logic [2:0] SRC [8] = '{3'h0, 3'h4, 3'h2, 3'h4, 3'h1, 3'h1, 3'h2, 3'h1};
  localparam logic [2:0] SNK [8] = '{3'h0, 3'h2, 3'h1, 3'h1, 3'h4, 3'h2, 3'h4, 3'h6};
  logic          sys_clk = 1'b0;
  logic          rst_n = 1'b0;
  logic [1:0]    scheme_select = 2'h0;
  logic          freewheel_select_bit = 1'b0;
  phase_inputs_t phase_in;
  gate_cmds_t    gate_out;
  int            num_errors = 0;
  int            checked = 0;

  always #20 sys_clk = ~sys_clk;

  ctrl_model ctrl (.phase_in(phase_in));
  three_phase_pwm_input_decoder uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .scheme_select(scheme_select), .freewheel_select_bit(freewheel_select_bit),
    .phase_in(phase_in), .gate_out(gate_out));

  // Reference gate mapping
  function automatic gate_cmds_t expect_gates(input logic [1:0] sch, input logic fw,
                                              input phase_inputs_t pin);
    logic [2:0] hi, lo, rot;
    hi = pin.phase_high_input;
    lo = pin.phase_low_input;
    rot = {lo[0], hi[1], lo[1]};
    if (hi[2] && rot != 3'h0 && rot != 3'h7) rot = ~rot;
    case (sch)
      SCHEME_SIX:   return '{hi & ~lo, lo & ~hi};
      SCHEME_THREE: return '{hi & lo, ~hi & lo};
      SCHEME_INDEP: return '{hi, lo};
      default: begin
        if (!lo[2]) return '{3'h0, 3'h7};
        return '{SRC[rot] & {3{hi[0]}}, SNK[rot] | (SRC[rot] & {3{~hi[0] & ~fw}})};
      end
    endcase
  endfunction

  task automatic check(input string what, input gate_cmds_t exp, input gate_cmds_t seen);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One cycle later, compare registered gates
  task automatic settle(input string what);
    @(posedge sys_clk);
    #1;
    check(what, expect_gates(scheme_select, freewheel_select_bit, phase_in), gate_out);
  endtask

  // Inputs low, switch scheme, then every pin pattern back to back
  task automatic sweep(input string what, input logic [1:0] sch, input logic fw);
    ctrl.put(3'h0, 3'h0);
    scheme_select = sch;
    freewheel_select_bit = fw;
    settle(what);
    for (int i = 0; i < 64; i++) begin
      if (sch == SCHEME_SINGLE) ctrl.put_single(i[0], i[3:1], i[4], i[5]);
      else ctrl.put(i[2:0], i[5:3]);
      settle(what);
    end
    $display("%s done", what);
  endtask

  // Reset mid-run clears gates
  task automatic t_reset();
    ctrl.put(3'h7, 3'h7);
    scheme_select = SCHEME_INDEP;
    settle("before reset");
    rst_n = 1'b0;
    #1;
    check("gates in reset", '{GATES_RESET, GATES_RESET}, gate_out);
    @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    settle("after reset");
    $display("reset done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    sweep("six input", SCHEME_SIX, 1'b1);
    sweep("three input", SCHEME_THREE, 1'b0);
    sweep("single sync", SCHEME_SINGLE, 1'b0);
    sweep("single freewheel", SCHEME_SINGLE, 1'b1);
    sweep("independent", SCHEME_INDEP, 1'b0);
    t_reset();
    conclude();
  end

  // Watchdog far beyond the few hundred cycles needed
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
endmodule // tb_three_phase_pwm_input_decoder

`default_nettype wire
